/* verilog/acc_top.sv */
`timescale 1ns/1ps
// Functional notes
// [R1] four channels A-D, each with own settings
// [R2] AB byte: A in 7:4, B in 3:0
// [R3] CD byte: C upper nibble, D lower nibble
// [R4] two 8-bit threshold codes drive ladders
// [R5] software zeroes unused threshold codes
// [R6] channel A choice: first or second code
// [R7] channels B-D choice: first or external
// [R8] invert bit flips the comparator result
// [R9] status 3:0 live outputs, low when off
// [R10] status 7:4 sticky flags D,C,B,A
// [R11] flag set on any live edge while on
// [R12] flags stay until software clears them
// [R13] irq allow bit gates a flag's request
// [R14] status write loads hysteresis codes
// [R15] software waits 20us after enabling
// [R16] software routes pin analog, drivers off
// [R17] write 0 clears flag; toggle wins
// [R18] interrupt is OR of allowed flags
module acc_top (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [19:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [3:0]  CMP_RAW,
    output logic      [3:0]  CMP_ON,
    output logic      [3:0]  REF_CHOICE,
    output logic      [7:0]  THRESHOLD_LEVEL_FIRST,
    output logic      [7:0]  THRESHOLD_LEVEL_SECOND,
    output logic      [1:0]  HYST_CODE_A,
    output logic      [1:0]  HYST_CODE_BCD,
    output logic             IRQ
);
    logic [7:0]  cfg_ab;
    logic [7:0]  cfg_cd;
    logic [7:0]  thr_first;
    logic [7:0]  thr_second;
    logic [3:0]  hyst;
    logic [31:0] prdata;
    logic        irq;

    logic [3:0]  raw_s;
    logic [3:0]  cmp_on;
    logic [3:0]  ref_choice;
    logic [3:0]  irq_allow;
    logic [3:0]  invert_out;
    logic [3:0]  live_out;
    logic [3:0]  toggle;
    logic [3:0]  edge_flag;
    logic [3:0]  flag_clr;

    wire  [17:0] word_idx = PADDR[19:2];
    wire         aligned  = (PADDR[1:0] == 2'h0);
    wire         setup    = PSEL & ~PENABLE;
    wire         access   = PSEL & PENABLE;

    // one setting bit of channel ch; A,C upper nibble, B,D lower
    function automatic logic pick(input logic [7:0] ab,
                                  input logic [7:0] cd,
                                  input int         ch,
                                  input int         pos);
        logic [7:0] cfg;
        int         bitpos;
        cfg    = (ch < 2) ? ab : cd;
        bitpos = ((ch % 2) == 0) ? pos + acc_pkg::ACC_NIB_HI : pos;
        return cfg[bitpos];
    endfunction

    // address match on a whole aligned word
    function automatic logic hit(input logic [17:0] idx,
                                 input logic [17:0] reg_idx,
                                 input logic        al);
        return al && (idx == reg_idx);
    endfunction

    // register decode
    wire sel_status = hit(word_idx, acc_pkg::ACC_IDX_STATUS, aligned);
    wire sel_ab     = hit(word_idx, acc_pkg::ACC_IDX_CFG_AB, aligned);
    wire sel_cd     = hit(word_idx, acc_pkg::ACC_IDX_CFG_CD, aligned);
    wire sel_thr1   = hit(word_idx, acc_pkg::ACC_IDX_THR_1, aligned);
    wire sel_thr2   = hit(word_idx, acc_pkg::ACC_IDX_THR_2, aligned);
    wire sel_any    = sel_status | sel_ab | sel_cd | sel_thr1 | sel_thr2;

    // zero-wait slave; unmapped or unaligned access answers with error
    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~sel_any;

    wire wr_go     = access & PWRITE;
    wire wr_status = wr_go & sel_status;
    wire wr_ab     = wr_go & sel_ab;
    wire wr_cd     = wr_go & sel_cd;
    wire wr_thr1   = wr_go & sel_thr1;
    wire wr_thr2   = wr_go & sel_thr2;

    // read view of the status byte: flags over live outputs
    wire [7:0] status_view = {edge_flag, live_out};         // [R9] [R10]

    wire [7:0] rd_byte = sel_status ? status_view :
                         sel_ab     ? cfg_ab      :
                         sel_cd     ? cfg_cd      :
                         sel_thr1   ? thr_first   :
                         sel_thr2   ? thr_second  : 8'h00;

    // read data is captured in setup so it stands through access
    wire rd_cap = setup & ~PWRITE;

    // per-channel settings split out of the two config bytes
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_set
            assign cmp_on[ch]     = pick(cfg_ab, cfg_cd, ch,
                                         acc_pkg::ACC_POS_ON);     // [R1]
            assign ref_choice[ch] = pick(cfg_ab, cfg_cd, ch,
                                         acc_pkg::ACC_POS_CHOICE);
            assign irq_allow[ch]  = pick(cfg_ab, cfg_cd, ch,
                                         acc_pkg::ACC_POS_IRQ);
            assign invert_out[ch] = pick(cfg_ab, cfg_cd, ch,
                                         acc_pkg::ACC_POS_INV);
            // a zero written at the flag position clears it
            assign flag_clr[ch] = wr_status
                & ~PWDATA[acc_pkg::ACC_FLAG_LSB + ch];      // [R17]
        end
    endgenerate

    // comparator outputs are analog-side, so synchronise first
    acc_sync #(
        .WIDTH  (4),
        .STAGES (acc_pkg::ACC_SYNC_STAGES)
    ) u_sync (
        .CLK_SYS  (CLK_SYS),
        .RST_N    (RST_N),
        .async_in (CMP_RAW),
        .sync_out (raw_s)
    );

    // live output, edge detect and sticky flag per channel
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_chan
            acc_chan u_chan (
                .CLK_SYS    (CLK_SYS),
                .RST_N      (RST_N),
                .raw_s      (raw_s[ch]),
                .cmp_on     (cmp_on[ch]),
                .invert_out (invert_out[ch]),                  // [R8]
                .flag_clr   (flag_clr[ch]),                   // [R12]
                .live_out   (live_out[ch]),                    // [R9]
                .toggle     (toggle[ch]),                     // [R11]
                .edge_flag  (edge_flag[ch])
            );
        end
    endgenerate

    // config bytes and threshold codes
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            cfg_ab     <= acc_pkg::ACC_RST_CFG;
            cfg_cd     <= acc_pkg::ACC_RST_CFG;
            thr_first  <= acc_pkg::ACC_RST_THR;
            thr_second <= acc_pkg::ACC_RST_THR;
        end
        else
        begin
            if (wr_ab)
                cfg_ab <= PWDATA[7:0];                         // [R2]
            if (wr_cd)
                cfg_cd <= PWDATA[7:0];                         // [R3]
            if (wr_thr1)
                thr_first <= PWDATA[7:0];                      // [R4]
            if (wr_thr2)
                thr_second <= PWDATA[7:0];                     // [R4]
        end
    end

    // hysteresis codes are write-only; reads show flags and outputs
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
            hyst <= acc_pkg::ACC_RST_HYST;
        else if (wr_status)
            hyst <= PWDATA[3:0];                              // [R14]
    end

    // read data and the interrupt line, both from flops
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            prdata <= 32'h0000_0000;
            irq    <= 1'b0;
        end
        else
        begin
            if (rd_cap)
                prdata <= {24'h00_0000, rd_byte};
            irq <= |(edge_flag & irq_allow);             // [R13] [R18]
        end
    end

    // outputs toward the bus and the analog side
    assign PRDATA                 = prdata;
    assign IRQ                    = irq;
    assign CMP_ON                 = cmp_on;
    // bit 0: first/second code; bits 3:1: first code/external input
    assign REF_CHOICE             = ref_choice;               // [R6] [R7]
    assign THRESHOLD_LEVEL_FIRST  = thr_first;
    assign THRESHOLD_LEVEL_SECOND = thr_second;
    assign HYST_CODE_A   = hyst[acc_pkg::ACC_HYST_A_LSB +: 2];
    assign HYST_CODE_BCD = hyst[acc_pkg::ACC_HYST_BCD_LSB +: 2];

    // checks on the register map and the flag behaviour
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    // each config nibble lands on its own channel
    ab_layout_a: assert property (wr_ab |=> // [R2]
        CMP_ON[0] == $past(PWDATA[7]) && REF_CHOICE[0] == $past(PWDATA[6])
        && CMP_ON[1] == $past(PWDATA[3]) && REF_CHOICE[1] == $past(PWDATA[2]))
        else $error("ab config byte not mapped to channels a and b");

    ab_setting_a: assert property (wr_ab |=> // [R2]
        irq_allow[0] == $past(PWDATA[5]) && invert_out[0] == $past(PWDATA[4])
        && irq_allow[1] == $past(PWDATA[1])
        && invert_out[1] == $past(PWDATA[0]))
        else $error("ab irq allow or invert bits misplaced");

    // C takes the upper nibble, D the lower one
    cd_layout_a: assert property (wr_cd |=> // [R3]
        CMP_ON[2] == $past(PWDATA[7]) && CMP_ON[3] == $past(PWDATA[3])
        && REF_CHOICE[3] == $past(PWDATA[2]))
        else $error("cd config byte not mapped to channels c and d");

    cd_setting_a: assert property (wr_cd |=> // [R3]
        REF_CHOICE[2] == $past(PWDATA[6]) && irq_allow[2] == $past(PWDATA[5])
        && invert_out[2] == $past(PWDATA[4])
        && irq_allow[3] == $past(PWDATA[1])
        && invert_out[3] == $past(PWDATA[0]))
        else $error("cd choice, irq allow or invert bits misplaced");

    // a threshold write touches only its own code
    thr_code_a: assert property (wr_thr2 && !wr_thr1 |=> // [R4]
        THRESHOLD_LEVEL_SECOND == $past(PWDATA[7:0])
        && $stable(THRESHOLD_LEVEL_FIRST))
        else $error("second threshold code not loaded alone");

    thr_first_a: assert property (wr_thr1 |=> // [R4]
        THRESHOLD_LEVEL_FIRST == $past(PWDATA[7:0])
        && $stable(THRESHOLD_LEVEL_SECOND))
        else $error("first threshold code not loaded alone");

    // status writes load hysteresis, reads show flags and outputs
    // hysteresis is write-only, so only its outputs can be checked
    hyst_load_a: assert property (wr_status |=> // [R14]
        HYST_CODE_BCD == $past(PWDATA[3:2]) && HYST_CODE_A == $past(PWDATA[1:0]))
        else $error("hysteresis codes not loaded from status write");

    status_read_a: assert property (rd_cap && sel_status |=> // [R10]
        PRDATA[7:0] == {$past(edge_flag), $past(live_out)}
        && PRDATA[31:8] == 24'h00_0000)
        else $error("status read shows wrong flags or outputs");

    // read data stands until the next read setup
    read_hold_a: assert property (!rd_cap |=> $stable(PRDATA)) // [R10]
        else $error("read data moved outside a read setup");

    // only the low byte carries data; the rest reads zero
    data_hi_a: assert property (PRDATA[31:8] == 24'h00_0000) // [R10]
        else $error("read data above the low byte not zero");

    // interrupt follows the allowed flags one cycle late
    // a registered line trades one cycle of lag for a clean output
    irq_gate_a: assert property ((edge_flag & irq_allow) == 4'h0 // [R18]
        |=> !IRQ)
        else $error("interrupt raised with no allowed flag");

    irq_source_a: assert property (IRQ |-> // [R18]
        $past((edge_flag & irq_allow) != 4'h0))
        else $error("interrupt high with no allowed flag before");

    // refused addresses answer with error and change nothing
    unmapped_a: assert property (access && !sel_any |-> PSLVERR) // [R1]
        else $error("unmapped access not answered with error");

    wr_refused_a: assert property (wr_go && !sel_any |=> // [R2]
        $stable(cfg_ab) && $stable(cfg_cd) && $stable(thr_first)
        && $stable(thr_second) && $stable(hyst))
        else $error("refused write changed a register");

    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_chk
            // live output: forced low when off, else synced raw xor invert
            live_gate_a: assert property (!cmp_on[ch] |-> // [R9]
                !live_out[ch])
                else $error("live output high while channel off");

            // polarity check reaches back past both synchroniser stages
            live_pol_a: assert property (cmp_on[ch] |-> // [R8]
                live_out[ch] == ($past(CMP_RAW[ch], 2) ^ invert_out[ch]))
                else $error("live output polarity wrong");

            // edges set flags only while on; nothing else sets them
            edge_set_a: assert property ($changed(live_out[ch]) // [R11]
                && cmp_on[ch] |=> edge_flag[ch])
                else $error("edge while on did not set the flag");

            off_quiet_a: assert property (!cmp_on[ch] // [R11]
                && !edge_flag[ch] |=> !edge_flag[ch])
                else $error("flag set while channel off");

            // only a written zero clears a flag, and a toggle beats it
            flag_hold_a: assert property (edge_flag[ch] // [R12]
                && !flag_clr[ch] |=> edge_flag[ch])
                else $error("flag dropped without software clear");

            flag_clear_a: assert property (flag_clr[ch] // [R17]
                && !toggle[ch] |=> !edge_flag[ch])
                else $error("flag not cleared by write of zero");

            set_wins_a: assert property (flag_clr[ch] // [R17]
                && toggle[ch] |=> edge_flag[ch])
                else $error("clear beat a same-cycle toggle");

            // an allowed flag raises the interrupt
            irq_raise_a: assert property (edge_flag[ch] // [R13]
                && irq_allow[ch] |=> IRQ)
                else $error("allowed flag raised no interrupt");
        end
    endgenerate

    // main scenarios: flag then clear, interrupt, race, error, far pair
    flag_set_c: cover property (toggle[0] ##[1:20] flag_clr[0]);
    irq_c: cover property (!IRQ ##1 IRQ);
    race_c: cover property (flag_clr[2] && toggle[2]);
    err_c: cover property (PSLVERR);
    cd_irq_c: cover property (toggle[3] && irq_allow[3]);
endmodule

/* verilog/acc_pkg.sv */
package acc_pkg;

    // register indices; byte address is four times the index
    localparam logic [17:0] ACC_IDX_STATUS = 18'h00094;
    localparam logic [17:0] ACC_IDX_CFG_AB = 18'h0A030;
    localparam logic [17:0] ACC_IDX_CFG_CD = 18'h0A031;
    localparam logic [17:0] ACC_IDX_THR_1  = 18'h0A032;
    localparam logic [17:0] ACC_IDX_THR_2  = 18'h0A033;

    // values after reset
    localparam logic [7:0] ACC_RST_CFG  = 8'h00;
    localparam logic [7:0] ACC_RST_THR  = 8'h00;
    localparam logic [3:0] ACC_RST_HYST = 4'h0;

    // bit positions inside one channel nibble of a config byte
    localparam int ACC_POS_ON     = 3;
    localparam int ACC_POS_CHOICE = 2;
    localparam int ACC_POS_IRQ    = 1;
    localparam int ACC_POS_INV    = 0;
    localparam int ACC_NIB_HI     = 4;

    // status byte layout
    localparam int ACC_FLAG_LSB     = 4;
    localparam int ACC_LIVE_LSB     = 0;
    localparam int ACC_HYST_A_LSB   = 0;
    localparam int ACC_HYST_BCD_LSB = 2;

    // synchroniser depth for comparator outputs
    localparam int ACC_SYNC_STAGES = 2;

endpackage

/* verilog/acc_sync.sv */
`timescale 1ns/1ps
module acc_sync #(
    parameter int WIDTH  = 4,
    parameter int STAGES = acc_pkg::ACC_SYNC_STAGES
) (
    input  wire logic             CLK_SYS,
    input  wire logic             RST_N,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage [STAGES];

    // first stage feeds only the next stage, never any logic
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            for (int s = 0; s < STAGES; s++)
                stage[s] <= '0;
        end
        else
        begin
            stage[0] <= async_in;
            for (int s = 1; s < STAGES; s++)
                stage[s] <= stage[s-1];
        end
    end

    assign sync_out = stage[STAGES-1];
endmodule

/* verilog/acc_chan.sv */
`timescale 1ns/1ps
module acc_chan (
    input  wire logic CLK_SYS,
    input  wire logic RST_N,
    input  wire logic raw_s,
    input  wire logic cmp_on,
    input  wire logic invert_out,
    input  wire logic flag_clr,
    output logic      live_out,
    output logic      toggle,
    output logic      edge_flag
);
    logic live_prev;
    logic next_flag;

    // polarity first, then forced low while the channel is off
    assign live_out = cmp_on & (raw_s ^ invert_out);
    // any edge of the live output while on; switching off never sets
    assign toggle = cmp_on & (live_out ^ live_prev);
    // a toggle in the same cycle as a clear wins
    assign next_flag = toggle | (edge_flag & ~flag_clr);

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            live_prev <= 1'b0;
            edge_flag <= 1'b0;
        end
        else
        begin
            live_prev <= live_out;
            edge_flag <= next_flag;
        end
    end
endmodule

/* tb/acc_cmp_model.sv */
`timescale 1ns/1ps
module acc_cmp_model (
    input  wire logic        clk,
    input  wire logic [3:0]  on,
    input  wire logic [3:0]  choice,
    input  wire logic [7:0]  thr_first,
    input  wire logic [7:0]  thr_second,
    input  wire logic [7:0]  thr_ext,
    input  wire logic [31:0] vin,
    output logic      [3:0]  raw
);
    logic       wobble = 1'b0;
    logic [7:0] thr [4];

    // ladder code is one of 256 equal steps
    always_comb
    begin
        thr[0] = choice[0] ? thr_second : thr_first;
        for (int i = 1; i < 4; i++)
            thr[i] = choice[i] ? thr_ext : thr_first;
    end

    // an unbiased comparator is junk, so let it wander
    always @(posedge clk)
        wobble <= ~wobble;

    // vin stands for pins routed to analog, drivers off
    // input above threshold drives the raw output high
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            raw[i] = on[i] ? (vin[i*8 +: 8] > thr[i]) : wobble;
    end
endmodule

/* tb/test_analog_comparator_control.sv */
`timescale 1ns/1ps
module test_analog_comparator_control;
    localparam logic [19:0] A_ST = {acc_pkg::ACC_IDX_STATUS, 2'b00};
    localparam logic [19:0] A_AB = {acc_pkg::ACC_IDX_CFG_AB, 2'b00};
    localparam logic [19:0] A_CD = {acc_pkg::ACC_IDX_CFG_CD, 2'b00};
    localparam logic [19:0] A_T1 = {acc_pkg::ACC_IDX_THR_1, 2'b00};
    localparam logic [19:0] A_T2 = {acc_pkg::ACC_IDX_THR_2, 2'b00};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [19:0] padr = 20'h00000;
    logic [31:0] pwd = 32'h00000000;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic [3:0]  raw;
    logic [3:0]  on;
    logic [3:0]  ch;
    logic [7:0]  t1;
    logic [7:0]  t2;
    logic [1:0]  hya;
    logic [1:0]  hyb;
    logic        irq;
    logic [7:0]  ext = 8'h00;
    logic [31:0] vin = 32'h00000000;
    logic [31:0] q;
    logic        e;
    int          err_total = 0;
    int          checks = 0;

    acc_top uut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
        .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .CMP_RAW(raw),
        .CMP_ON(on), .REF_CHOICE(ch), .THRESHOLD_LEVEL_FIRST(t1),
        .THRESHOLD_LEVEL_SECOND(t2), .HYST_CODE_A(hya),
        .HYST_CODE_BCD(hyb), .IRQ(irq));
    acc_cmp_model far (.clk(clk), .on(on), .choice(ch), .thr_first(t1),
        .thr_second(t2), .thr_ext(ext), .vin(vin), .raw(raw));

    // 20 MHz system clock
    initial
    begin
        forever #25 clk = ~clk;
    end

    task close_out;
    begin
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    begin
        checks++;
        if (s !== x)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    end
    endtask

    // one apb transfer; the wait for ready is bounded
    task bus(input logic w, input logic [19:0] a, input logic [7:0] d);
        int n;
    begin
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        padr <= a;
        pwd <= {24'h000000, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                err_total++;
                close_out();
            end
            @(posedge clk);
        end
        q = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    end
    endtask

    task rd(input string nm, input logic [19:0] a, input logic [7:0] x);
    begin
        bus(1'b0, a, 8'h00);
        chk(nm, q, {24'h000000, x});
    end
    endtask

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task t_reset;
    begin
        bus(1'b1, A_AB + 20'h00001, 8'hFF);
        chk("unaligned_err", {31'h0, e}, 32'h1);
        rd("cfg_ab", A_AB, 8'h00);
        rd("cfg_cd", A_CD, 8'h00);
        rd("thr_first", A_T1, 8'h00);
        rd("thr_second", A_T2, 8'h00);
        rd("status", A_ST, 8'h00);
        bus(1'b0, 20'h00010, 8'h00);
        chk("unmapped_err", {31'h0, e}, 32'h1);
    end
    endtask

    task t_cfg;
    begin
        bus(1'b1, A_AB, 8'h9A);
        bus(1'b1, A_CD, 8'h4C);
        bus(1'b1, A_T1, 8'hFF);
        bus(1'b1, A_T2, 8'h00);
        wt(1);
        chk("enables", {28'h0, on}, 32'hB);
        chk("choices", {28'h0, ch}, 32'hC);
        chk("first_code", {24'h0, t1}, 32'hFF);
        chk("second_code", {24'h0, t2}, 32'h0);
        rd("cfg_ab_back", A_AB, 8'h9A);
        rd("cfg_cd_back", A_CD, 8'h4C);
    end
    endtask

    task t_route;
    begin
        bus(1'b1, A_CD, 8'h00);
        bus(1'b1, A_T1, 8'h80);
        bus(1'b1, A_T2, 8'h20);
        ext <= 8'h10;
        vin <= 32'h00004040;
        bus(1'b1, A_AB, 8'hC8);
        wt(400); // bias settling after enable
        bus(1'b1, A_ST, 8'h00);
        rd("live_ab", A_ST, 8'h01);
        bus(1'b1, A_AB, 8'hDC);
        wt(6);
        rd("live_inv", A_ST, 8'h32);
    end
    endtask

    task t_irq;
    begin
        bus(1'b1, A_AB, 8'hA0);
        vin <= 32'h00000000;
        wt(6);
        bus(1'b1, A_ST, 8'h00);
        wt(2);
        chk("irq_idle", {31'h0, irq}, 32'h0);
        vin <= 32'h000000FF;
        wt(6);
        chk("irq_on", {31'h0, irq}, 32'h1);
        bus(1'b1, A_AB, 8'h80);
        wt(2);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        rd("flag_kept", A_ST, 8'h11);
        bus(1'b1, A_ST, 8'hF0);
        rd("flag_keep", A_ST, 8'h11);
        bus(1'b1, A_ST, 8'hE7);
        wt(1);
        chk("hyst_a", {30'h0, hya}, 32'h3);
        chk("hyst_bcd", {30'h0, hyb}, 32'h1);
        rd("flag_clr", A_ST, 8'h01);
    end
    endtask

    task t_off;
    begin
        bus(1'b1, A_CD, 8'h33);
        bus(1'b1, A_AB, 8'h00);
        bus(1'b1, A_ST, 8'h00);
        vin <= 32'hFFFF0000;
        wt(6);
        vin <= 32'h00000000;
        wt(6);
        rd("off_quiet", A_ST, 8'h00);
        bus(1'b1, A_T1, 8'h00); // unused ladder parked low
        bus(1'b1, A_T2, 8'h00);
    end
    endtask

    task t_cd;
    begin
        ext <= 8'h10; // external threshold for C and D
        bus(1'b1, A_CD, 8'hDE);
        wt(400); // bias settling after enable
        bus(1'b1, A_ST, 8'h00);
        rd("live_cd", A_ST, 8'h04);
        vin <= 32'h20200000;
        wt(6);
        chk("irq_d", {31'h0, irq}, 32'h1);
        rd("flags_cd", A_ST, 8'hC8);
        bus(1'b1, A_ST, 8'h00);
        bus(1'b1, A_CD, 8'h00);
    end
    endtask

    // reset, then each scenario in turn
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_cfg();
        t_route();
        t_irq();
        t_off();
        t_cd();
        close_out();
    end
endmodule
